// ==== core/cxe_regs.vh ====
`ifndef CXE_REGS_VH
`define CXE_REGS_VH
// opcode fields
`define CXE_CMP_OPC      7'h31
`define CXE_CMP_OPC_MSB  15
`define CXE_CMP_OPC_LSB  9
`define CXE_XOR_OPC      6'h06
`define CXE_XOR_OPC_MSB  15
`define CXE_XOR_OPC_LSB  10
`define CXE_DEST_BIT     9
`define CXE_BANK_BIT     8
// highest file address that goes indexed in extended mode
`define CXE_INDEX_LIMIT  8'h5F
// access bank: addresses below 0x60 from bank 0, 0x60 and up from the special bank
`define CXE_ACC_SPLIT    8'h60
`define CXE_SFR_BANK     4'hF
`define CXE_NOP_WORD     16'h0000
// phase codes of one instruction cycle
`define CXE_Q1           2'h0
`define CXE_Q2           2'h1
`define CXE_Q3           2'h2
`define CXE_Q4           2'h3
`endif

// ==== core/cxe_phase_gen.v ====
`timescale 1ns/1ps
module cxe_phase_gen (
   mclk,
   reset_n,
   phase,
   cycleStart
);
`include "cxe_regs.vh"
   input  wire       mclk;
   input  wire       reset_n;
   output reg  [1:0] phase;
   output reg        cycleStart;

   // four clocks make one instruction cycle
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         phase      <= `CXE_Q1;
         // the first edge after release is a decode edge, so the strobe starts high
         cycleStart <= 1'b1;
      end else begin
         phase      <= phase + 2'h1;
         cycleStart <= (phase == `CXE_Q4);
      end
   end
endmodule

// ==== core/cxe_exec_core.v ====
`timescale 1ns/1ps
module cxe_exec_core (
   mclk,
   reset_n,
   instrWord,
   instrValid,
   nextIsTwoWord,
   extendedEnable,
   bankSelector,
   indexBase,
   fileReadData,
   fileAddr,
   fileRead,
   fileWriteData,
   fileWrite,
   accumulator,
   flagNegative,
   flagZero,
   skipActive,
   instrDone
);
`include "cxe_regs.vh"
   parameter ADDR_W = 12;
   input  wire              mclk;
   input  wire              reset_n;
   input  wire [15:0]       instrWord;
   input  wire              instrValid;
   input  wire              nextIsTwoWord;
   input  wire              extendedEnable;
   input  wire [3:0]        bankSelector;
   input  wire [ADDR_W-1:0] indexBase;
   input  wire [7:0]        fileReadData;
   output reg  [ADDR_W-1:0] fileAddr;
   output reg               fileRead;
   output reg  [7:0]        fileWriteData;
   output reg               fileWrite;
   output reg  [7:0]        accumulator;
   output reg               flagNegative;
   output reg               flagZero;
   output reg               skipActive;
   output reg               instrDone;

   wire [1:0] phase;
   wire       cycleStart;

   cxe_phase_gen i_cxe_phase_gen (
      .mclk       (mclk),
      .reset_n    (reset_n),
      .phase      (phase),
      .cycleStart (cycleStart)
   );

   reg  [15:0] opcode_reg;
   reg         opValid_reg;
   reg  [1:0]  skipLeft_reg;
   reg  [7:0]  result_reg;
   reg         skipPend_reg;

   wire isCmp = (opcode_reg[`CXE_CMP_OPC_MSB:`CXE_CMP_OPC_LSB] == `CXE_CMP_OPC);
   wire isXor = (opcode_reg[`CXE_XOR_OPC_MSB:`CXE_XOR_OPC_LSB] == `CXE_XOR_OPC);
   wire destFile = opcode_reg[`CXE_DEST_BIT];
   wire bankBit  = opcode_reg[`CXE_BANK_BIT];
   wire [7:0] fAddr = opcode_reg[7:0];

   // addressing mode of the current word; the bank bit wins over everything
   localparam MODE_LOW   = 2'h0;
   localparam MODE_HIGH  = 2'h1;
   localparam MODE_INDEX = 2'h2;
   localparam MODE_BANK  = 2'h3;
   reg [1:0] addrMode;
   always @* begin
      if (bankBit) begin
         addrMode = MODE_BANK;
      end else if (extendedEnable && (fAddr <= `CXE_INDEX_LIMIT)) begin
         addrMode = MODE_INDEX;
      end else if (fAddr < `CXE_ACC_SPLIT) begin
         addrMode = MODE_LOW;
      end else begin
         addrMode = MODE_HIGH;
      end
   end

   // effective data address
   reg [ADDR_W-1:0] effAddr;
   always @* begin
      case (addrMode)
         MODE_BANK: begin
            effAddr = {bankSelector, fAddr};
         end
         MODE_INDEX: begin
            // the index base wraps silently at the top of data memory
            effAddr = indexBase + {{(ADDR_W-8){1'b0}}, fAddr};
         end
         MODE_HIGH: begin
            effAddr = {`CXE_SFR_BANK, fAddr};
         end
         default: begin
            effAddr = {4'h0, fAddr};
         end
      endcase
   end

   wire [7:0] xorVal = accumulator ^ fileReadData;
   wire       equal  = (fileReadData == accumulator);
   // only the two known opcodes take part; any other word runs as a silent cycle
   wire       live   = opValid_reg && (isCmp || isXor);
   wire       inQ2   = (phase == `CXE_Q2);
   wire       inQ3   = (phase == `CXE_Q3);
   wire       inQ4   = (phase == `CXE_Q4);

   // word latch: a word owed to a skip is dropped before it can reach the file port
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         opcode_reg  <= `CXE_NOP_WORD;
         opValid_reg <= 1'b0;
      end else if (cycleStart) begin
         if (skipLeft_reg != 2'h0) begin
            opValid_reg <= 1'b0;
         end else begin
            opcode_reg  <= instrWord;
            opValid_reg <= instrValid;
         end
      end
   end

   // skip counter: armed at Q4 of an equal compare, spent one per cycle start
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         skipLeft_reg <= 2'h0;
      end else if (cycleStart) begin
         if (skipLeft_reg != 2'h0) begin
            skipLeft_reg <= skipLeft_reg - 2'h1;
         end
      end else if (inQ4 && live && skipPend_reg) begin
         // the next word is not decoded here, so the fetch side flags its size
         skipLeft_reg <= nextIsTwoWord ? 2'h2 : 2'h1;
      end
   end

   // stands for every no-op cycle of a taken skip
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         skipActive <= 1'b0;
      end else if (cycleStart) begin
         skipActive <= (skipLeft_reg != 2'h0);
      end
   end

   // read side of the file port: address and strobe at Q2
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         fileAddr <= {ADDR_W{1'b0}};
         fileRead <= 1'b0;
      end else begin
         fileRead <= inQ2 && live;
         if (inQ2 && live) begin
            fileAddr <= effAddr;
         end
      end
   end

   // write side: only an xor with the file destination writes back
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         fileWriteData <= 8'h00;
         fileWrite     <= 1'b0;
      end else begin
         fileWrite <= inQ4 && live && isXor && destFile;
         if (inQ4 && live && isXor && destFile) begin
            fileWriteData <= result_reg;
         end
      end
   end

   // result and compare outcome are caught at Q3, while the read byte is valid
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         result_reg   <= 8'h00;
         skipPend_reg <= 1'b0;
      end else if (inQ3) begin
         skipPend_reg <= live && isCmp && equal;
         if (live && isXor) begin
            result_reg <= xorVal;
         end
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         accumulator <= 8'h00;
      end else if (inQ4 && live && isXor && !destFile) begin
         accumulator <= result_reg;
      end
   end

   // flags follow the xor result whatever its destination; compare leaves them alone
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         flagNegative <= 1'b0;
         flagZero     <= 1'b0;
      end else if (inQ4 && live && isXor) begin
         flagNegative <= result_reg[7];
         flagZero     <= (result_reg == 8'h00);
      end
   end

   // one pulse per finished compare, xor or skip; a skipped two-word pair pulses once, at its end
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         instrDone <= 1'b0;
      end else begin
         instrDone <= inQ4 && (live || (skipActive && (skipLeft_reg == 2'h0)));
      end
   end
endmodule

// ==== tb/cxe_exec_core_props.sv ====
`timescale 1ns/1ps
module cxe_exec_core_props #(parameter ADDR_W = 12) (
   input wire logic              mclk,
   input wire logic              reset_n,
   input wire logic [15:0]       instrWord,
   input wire logic              extendedEnable,
   input wire logic [3:0]        bankSelector,
   input wire logic [ADDR_W-1:0] indexBase,
   input wire logic [7:0]        fileReadData,
   input wire logic [ADDR_W-1:0] fileAddr,
   input wire logic              fileRead,
   input wire logic [7:0]        fileWriteData,
   input wire logic              fileWrite,
   input wire logic [7:0]        accumulator,
   input wire logic              flagNegative,
   input wire logic              flagZero,
   input wire logic              skipActive,
   input wire logic              instrDone
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   wire [7:0]        fOff = instrWord[7:0];
   // the bench holds the word for the whole cycle, so the live word is the decoded one
   wire [ADDR_W-1:0] expAddr = instrWord[8] ? {bankSelector, fOff} :
      (extendedEnable && fOff <= 8'h5F) ? indexBase + fOff : {(fOff < 8'h60) ? 4'h0 : 4'hF, fOff};
   property p_addr; fileRead |-> fileAddr == expAddr; endproperty
   a_addr: assert property (p_addr) else $error("bad file address");
   property p_one_cycle; fileRead |-> ##2 instrDone; endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("late done");
   property p_done_pulse; instrDone |=> !instrDone; endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("long done");
   property p_write_time; fileWrite |-> $past(fileRead, 2); endproperty
   a_write_time: assert property (p_write_time) else $error("stray write");
   property p_write_data;
      fileWrite |-> fileWriteData == (accumulator ^ $past(fileReadData, 2));
   endproperty
   a_write_data: assert property (p_write_data) else $error("bad xor data");
   property p_flags;
      $changed(accumulator) |-> flagZero == (accumulator == 8'h00) && flagNegative == accumulator[7];
   endproperty
   a_flags: assert property (p_flags) else $error("bad flags");
   property p_skip_len; $rose(skipActive) |-> skipActive [*4]; endproperty
   a_skip_len: assert property (p_skip_len) else $error("short skip");
   property p_skip_quiet; skipActive |-> !fileRead && !fileWrite; endproperty
   a_skip_quiet: assert property (p_skip_quiet) else $error("access in skip");
   property p_skip_keep;
      skipActive |-> $stable(accumulator) && $stable(flagZero) && $stable(flagNegative);
   endproperty
   a_skip_keep: assert property (p_skip_keep) else $error("skip changed state");
endmodule
bind cxe_exec_core cxe_exec_core_props #(.ADDR_W(ADDR_W)) i_cxe_exec_core_props (.*);

// ==== tb/cxe_exec_core_bench.sv ====
`timescale 1ns/1ps
module cxe_exec_core_bench;
   reg         mclk = 1'b0;
   reg         resetN = 1'b0;
   reg         two = 1'b0;
   reg         ext = 1'b0;
   reg  [15:0] word = 16'h0000;
   reg  [7:0]  rdData = 8'h00;
   wire [11:0] addr;
   wire [7:0]  wrData;
   wire [7:0]  acc;
   wire        neg;
   wire        zero;
   wire        rd;
   wire        wr;
   wire        skp;
   wire        done;
   reg         rdSeen = 1'b0;
   integer     bad_count = 0;
   integer     check_count = 0;
   cxe_exec_core i_cxe_exec_core (.mclk(mclk), .reset_n(resetN), .instrWord(word),
      .instrValid(1'b1), .nextIsTwoWord(two), .extendedEnable(ext), .bankSelector(4'h3),
      .indexBase(12'h100), .fileReadData(rdData), .fileAddr(addr), .fileRead(rd),
      .fileWriteData(wrData), .fileWrite(wr), .accumulator(acc), .flagNegative(neg),
      .flagZero(zero), .skipActive(skp), .instrDone(done));
   initial forever #2 mclk = ~mclk;
   task chk(input [8*4:1] nm, input [11:0] got, input [11:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[ERR] %0s exp %h got %h", nm, exp, got);
         end
      end
   endtask
   // one instruction cycle is four edges; inputs move 1 ns after an edge
   task run(input [15:0] w, input [7:0] d);
      begin
         word = w;
         rdData = d;
         repeat (2) @(posedge mclk);
         #1;
         rdSeen = rd;
         repeat (2) @(posedge mclk);
         #1;
      end
   endtask
   task t_xor;
      begin
         run(16'h1910, 8'hAF);
         chk("acc", acc, 12'h0AF);
         chk("nz", {neg, zero}, 12'h002);
         chk("adr", addr, 12'h310);
         chk("rd", rdSeen, 12'h001);
         chk("wr", wr, 12'h000);
         chk("done", done, 12'h001);
         run(16'h1A80, 8'hB5);
         chk("wr", wrData, 12'h01A);
         chk("wr", wr, 12'h001);
         chk("acc", acc, 12'h0AF);
         chk("adr", addr, 12'hF80);
      end
   endtask
   task t_index;
      begin
         ext = 1'b1;
         run(16'h1820, 8'hAF);
         chk("adr", addr, 12'h120);
         chk("nz", {neg, zero}, 12'h001);
         run(16'h185F, 8'h00);
         chk("adr", addr, 12'h15F);
         run(16'h1860, 8'h00);
         chk("adr", addr, 12'hF60);
         ext = 1'b0;
      end
   endtask
   task t_skip;
      begin
         two = 1'b1;
         run(16'h6305, 8'h00);
         two = 1'b0;
         run(16'h1910, 8'hFF);
         chk("skp", skp, 12'h001);
         chk("rd", rdSeen, 12'h000);
         chk("done", done, 12'h000);
         run(16'h1910, 8'hFF);
         chk("skp", skp, 12'h001);
         chk("done", done, 12'h001);
         chk("acc", acc, 12'h000);
         chk("nz", {neg, zero}, 12'h001);
         run(16'h6305, 8'h01);
         run(16'h1910, 8'h0F);
         chk("acc", acc, 12'h00F);
         chk("skp", skp, 12'h000);
         run(16'h6305, 8'h0F);
         run(16'h1910, 8'hFF);
         chk("skp", skp, 12'h001);
         chk("acc", acc, 12'h00F);
         run(16'h1910, 8'hF0);
         chk("skp", skp, 12'h000);
         chk("acc", acc, 12'h0FF);
         run(16'h1C10, 8'h33);
         chk("acc", acc, 12'h0FF);
         chk("done", done, 12'h000);
         chk("rd", rdSeen, 12'h000);
      end
   endtask
   task t_reset;
      begin
         resetN = 1'b0;
         #1;
         chk("acc", acc, 12'h000);
         chk("nz", {neg, zero}, 12'h000);
         chk("skp", {skp, done, wr}, 12'h000);
         chk("adr", addr, 12'h000);
         repeat (2) @(posedge mclk);
         #1;
         resetN = 1'b1;
         run(16'h1910, 8'h5A);
         chk("acc", acc, 12'h05A);
         chk("adr", addr, 12'h310);
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d errors %0d", check_count, bad_count);
         if (bad_count == 0 && check_count > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   initial begin
      #2000;
      bad_count = bad_count + 1;
      complete_run;
   end
   initial begin
      repeat (8) @(posedge mclk);
      #1;
      resetN = 1'b1;
      t_xor;
      t_index;
      t_skip;
      t_reset;
      complete_run;
   end
endmodule
